// ### logic/alu_flags_pkg.sv
/*
  Constants for the ALU status flag register: bit positions, widths,
  operation codes and the flag update mask encoding.
  Assumes the core presents one ALU operation at a time.
*/
package alu_flags_pkg;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 5;
  localparam int NEG_BIT = 4;
  localparam int OVF_BIT = 3;
  localparam int ZERO_BIT = 2;
  localparam int NIB_BIT = 1;
  localparam int CARRY_BIT = 0;
  localparam int NIB_W = 4;
  localparam logic [FLAG_W-1:0] FLAGS_ALL = 5'h1F;
  localparam logic [FLAG_W-1:0] FLAGS_NONE = 5'h00;
  localparam logic [FLAG_W-1:0] FLAGS_NZ = 5'h14;
  localparam logic [FLAG_W-1:0] FLAGS_Z = 5'h04;
  localparam logic [DATA_W-1:0] FLAGS_ADDR = 8'hD8;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;
  localparam logic [DATA_W-1:0] TOP_ZERO = 8'h00;

  typedef enum logic [3:0] {
    OP_PASS,
    OP_ADD,
    OP_ADDC,
    OP_SUB,
    OP_SUBB,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_CLEAR,
    OP_SWAP
  } alu_op_e;
endpackage

// ### logic/alu_status_flags.sv
/*
  ALU with its arithmetic status flag register.
  Assumes the core executes one operation per cycle, gives the
  destination-is-flag-register indication and reads the register through
  the plain register port.
*/
// Operation
// - Only bits 4..0 exist; bits 7..5 read zero and ignore writes.
// - Flag-affecting op writing the flag register cannot write those flags.
// - Flags then take the op's flag results, e.g. clear sets zero.
// - Flag register is usable as an operand like any register.
// - Negative flag bit 4 copies result bit 7.
// - Overflow flag bit 3 set when signed result overflows sign bit.
// - Zero flag bit 2 set when result equals zero.
// - Nibble carry flag bit 1 is carry out of low nibble on add/sub.
// - Carry flag bit 0 is carry out of bit 7 on add/sub.
// - Subtract adds two's complement; carries mean no borrow when one.
`timescale 1ns/1ps
module alu_status_flags
  import alu_flags_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // Operation from the core
  input wire logic OP_VALID,
  input wire logic [3:0] OP_CODE,
  input wire logic [DATA_W-1:0] OP_A,
  input wire logic [DATA_W-1:0] OP_B,
  input wire logic DEST_IS_FLAGS,
  // Register port
  input wire logic [DATA_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  // Results
  output logic [DATA_W-1:0] REG_RDATA,
  output logic [DATA_W-1:0] RESULT,
  output logic RESULT_WR,
  output logic [DATA_W-1:0] FLAGS_OUT
);
  localparam int PAD_W = DATA_W - FLAG_W;

  // Flag register and its next value
  logic [FLAG_W-1:0] flags_r;
  wire logic [FLAG_W-1:0] flags_nxt;
  logic [FLAG_W-1:0] wr_flags;

  // Named views of the stored flags
  logic negative_flag;
  logic signed_overflow_flag;
  logic zero_flag;
  logic nibble_carry_flag;
  logic carry_flag;

  // Flags produced by the current operation
  logic neg_new;
  logic ovf_new;
  logic zero_new;
  logic nib_new;
  logic carry_new;
  logic [FLAG_W-1:0] new_flags;
  logic [FLAG_W-1:0] upd_mask;
  logic upd_none;

  // Datapath
  alu_op_e op;
  logic is_arith;
  logic [DATA_W-1:0] addend;
  logic cin;
  logic [DATA_W:0] sum;
  logic [NIB_W:0] nib_sum;
  logic [DATA_W-1:0] logic_res;
  logic [DATA_W-1:0] swapped;
  logic [DATA_W-1:0] res;
  logic sign_a;
  logic sign_b;
  logic sign_r;

  // Access decoding
  logic wr_hit;
  logic rd_hit;
  logic op_to_flags;

  // Registered outputs
  logic [DATA_W-1:0] res_r;
  logic [DATA_W-1:0] res_nxt;
  logic res_wr_r;
  logic res_wr_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // Address decoder shared by the write and read paths
  function automatic logic hits_flags(
    input logic [DATA_W-1:0] addr
  );
    return addr == FLAGS_ADDR;
  endfunction

  // Operations that run through the adder
  function automatic logic arith_op(
    input alu_op_e code
  );
    return code inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBB};
  endfunction

  // Operations that take the logic unit result
  function automatic logic logic_op(
    input alu_op_e code
  );
    return code inside {OP_AND, OP_OR, OP_XOR};
  endfunction

  // Flags that an operation updates
  function automatic logic [FLAG_W-1:0] flag_mask(
    input alu_op_e code
  );
    logic [FLAG_W-1:0] m;
    m = FLAGS_NONE;
    if (arith_op(code)) begin
      m = FLAGS_ALL;
    end else if (logic_op(code)) begin
      m = FLAGS_NZ;
    end else if (code == OP_CLEAR) begin
      m = FLAGS_Z;
    end
    return m;
  endfunction

  // Operation and access decoding
  assign op = alu_op_e'(OP_CODE);
  assign is_arith = arith_op(op);
  assign upd_mask = flag_mask(op);
  assign upd_none = (upd_mask == FLAGS_NONE);
  assign wr_hit = REG_WR && hits_flags(REG_ADDR);
  assign rd_hit = REG_RD && hits_flags(REG_ADDR);
  assign op_to_flags = OP_VALID && DEST_IS_FLAGS;

  // Only the five low bits of a write are stored
  assign wr_flags = REG_WDATA[FLAG_W-1:0];

  // Subtraction adds the inverted operand plus one, or plus the carry flag for OP_SUBB
  always_comb begin
    addend = OP_B;
    cin = 1'b0;
    unique case (op)
      OP_ADD: begin
        cin = 1'b0;
      end
      OP_ADDC: begin
        cin = flags_r[CARRY_BIT];
      end
      OP_SUB: begin
        addend = ~OP_B;
        cin = 1'b1;
      end
      OP_SUBB: begin
        addend = ~OP_B;
        cin = flags_r[CARRY_BIT];
      end
      default: begin
        addend = OP_B;
      end
    endcase
  end

  // Full-width sum
  always_comb begin
    sum = {1'b0, OP_A} + {1'b0, addend} + {{DATA_W{1'b0}}, cin};
  end

  // Low-nibble sum for the nibble carry
  always_comb begin
    nib_sum = {1'b0, OP_A[NIB_W-1:0]} + {1'b0, addend[NIB_W-1:0]}
      + {{NIB_W{1'b0}}, cin};
  end

  // Logic unit
  always_comb begin
    logic_res = TOP_ZERO;
    unique case (op)
      OP_AND: begin
        logic_res = OP_A & OP_B;
      end
      OP_OR: begin
        logic_res = OP_A | OP_B;
      end
      OP_XOR: begin
        logic_res = OP_A ^ OP_B;
      end
      default: begin
        logic_res = TOP_ZERO;
      end
    endcase
  end

  // Nibble swap
  assign swapped = {OP_A[NIB_W-1:0], OP_A[DATA_W-1:NIB_W]};

  // Result select
  always_comb begin
    res = OP_A;
    unique case (op)
      OP_PASS: begin
        res = OP_A;
      end
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
        res = sum[DATA_W-1:0];
      end
      OP_AND, OP_OR, OP_XOR: begin
        res = logic_res;
      end
      OP_CLEAR: begin
        res = TOP_ZERO;
      end
      OP_SWAP: begin
        res = swapped;
      end
      default: begin
        res = OP_A;
      end
    endcase
  end

  // Sign bits for the overflow test
  assign sign_a = OP_A[DATA_W-1];
  assign sign_b = addend[DATA_W-1];
  assign sign_r = res[DATA_W-1];

  // Flag values of the current operation
  assign neg_new = sign_r;
  assign ovf_new = is_arith && (sign_a == sign_b)
    && (sign_r != sign_a);
  assign zero_new = (res == TOP_ZERO);
  assign nib_new = nib_sum[NIB_W];
  assign carry_new = sum[DATA_W];

  always_comb begin
    new_flags = FLAGS_NONE;
    new_flags[NEG_BIT] = neg_new;
    new_flags[OVF_BIT] = ovf_new;
    new_flags[ZERO_BIT] = zero_new;
    new_flags[NIB_BIT] = nib_new;
    new_flags[CARRY_BIT] = carry_new;
  end

  // Per-bit next value; an op blocks the write for the flags it updates, and for all bits if it targets the flag register
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_W; gi++) begin : g_flag
      logic base_bit;
      logic keep_bit;
      logic op_bit;

      always_comb begin
        base_bit = flags_r[gi];
        if (wr_hit) begin
          base_bit = wr_flags[gi];
        end
      end

      always_comb begin
        keep_bit = base_bit;
        if (op_to_flags) begin
          keep_bit = flags_r[gi];
        end
      end

      always_comb begin
        op_bit = keep_bit;
        if (upd_mask[gi]) begin
          op_bit = new_flags[gi];
        end else if (op_to_flags && upd_none) begin
          op_bit = res[gi];
        end
      end

      assign flags_nxt[gi] = OP_VALID ? op_bit : base_bit;
    end
  endgenerate

  // Flag register
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      flags_r <= FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Named views of the stored flags
  assign negative_flag = flags_r[NEG_BIT];
  assign signed_overflow_flag = flags_r[OVF_BIT];
  assign zero_flag = flags_r[ZERO_BIT];
  assign nibble_carry_flag = flags_r[NIB_BIT];
  assign carry_flag = flags_r[CARRY_BIT];

  // Result path to other destinations
  always_comb begin
    res_nxt = res;
    res_wr_nxt = OP_VALID && !DEST_IS_FLAGS;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      res_r <= TOP_ZERO;
    end else begin
      res_r <= res_nxt;
    end
  end

  // Result write strobe
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      res_wr_r <= 1'b0;
    end else begin
      res_wr_r <= res_wr_nxt;
    end
  end

  // Register read port, data one cycle after the strobe
  always_comb begin
    rdata_nxt = TOP_ZERO;
    if (rd_hit) begin
      rdata_nxt = {{PAD_W{1'b0}}, flags_r};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      rdata_r <= TOP_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign RESULT = res_r;
  assign RESULT_WR = res_wr_r;
  assign FLAGS_OUT = {{PAD_W{1'b0}}, negative_flag, signed_overflow_flag,
    zero_flag, nibble_carry_flag, carry_flag};

endmodule // alu_status_flags

// ### tb/alu_status_flags_props.sv
/* Assertions on the flag register ports.
   Assumes the flag register sits at D8h. */
`timescale 1ns/1ps
module alu_status_flags_props
  import alu_flags_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic OP_VALID,
  input wire logic [3:0] OP_CODE,
  input wire logic [DATA_W-1:0] OP_A,
  input wire logic [DATA_W-1:0] OP_B,
  input wire logic DEST_IS_FLAGS,
  input wire logic [DATA_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic [DATA_W-1:0] REG_RDATA,
  input wire logic [DATA_W-1:0] RESULT,
  input wire logic [DATA_W-1:0] FLAGS_OUT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  wire add = OP_VALID && OP_CODE == 4'h1;
  wire nz = OP_VALID && OP_CODE inside {[1:7]} && !DEST_IS_FLAGS;
  wire fwr = REG_WR && REG_ADDR == 8'hD8;
  top_zero_a: assert property (FLAGS_OUT[7:5] == 0
    && REG_RDATA[7:5] == 0) else $error("top bits set");
  neg_copy_a: assert property (nz |=> FLAGS_OUT[4] == RESULT[7])
    else $error("negative flag wrong");
  zero_set_a: assert property (nz |=> FLAGS_OUT[2] == (RESULT == 0))
    else $error("zero flag wrong");
  add_carry_a: assert property (add |=>
    FLAGS_OUT[0] == ($past(OP_A) > ~$past(OP_B))) else $error("add carry");
  sub_borrow_a: assert property (OP_VALID && OP_CODE == 4'h3 |=>
    FLAGS_OUT[0] == ($past(OP_A) >= $past(OP_B))) else $error("sub borrow");
  clear_zero_a: assert property (OP_VALID && OP_CODE == 4'h8 |=>
    FLAGS_OUT == ($past(FLAGS_OUT) | 8'h04)) else $error("clear flags");
  flags_hold_a: assert property (!OP_VALID && !fwr |=> $stable(FLAGS_OUT))
    else $error("flags moved");
  reg_write_a: assert property (fwr && !OP_VALID |=>
    FLAGS_OUT == {3'b000, $past(REG_WDATA[4:0])}) else $error("flag write");
endmodule // alu_status_flags_props
bind alu_status_flags alu_status_flags_props u_props(.*);

// ### tb/alu_status_flags_tb.sv
/* Random ALU ops and register accesses against a flag model.
   Assumes flag register at D8h and flags zero after reset. */
`timescale 1ns/1ps
module alu_status_flags_tb;
  import alu_flags_pkg::*;
  logic CLK_SYS = 0, SRST = 1, OP_VALID, REG_WR, REG_RD, DEST_IS_FLAGS;
  logic [3:0] OP_CODE, o;
  logic [7:0] OP_A, OP_B, REG_ADDR, REG_WDATA, REG_RDATA, RESULT, FLAGS_OUT;
  logic RESULT_WR;
  logic [31:0] x = 32'h763B, t;
  logic [4:0] f = 0;
  int errors = 0, num_checks = 0, s, k, n, r, i;
  always #5 CLK_SYS = ~CLK_SYS;
  core_model u_core(.*);
  alu_status_flags u_dut(.*);
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task chk(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task rdq(input logic [7:0] a, e);
    u_core.acc(1'b0, a, 8'h00);
    @(negedge CLK_SYS);
    chk(REG_RDATA, e);
  endtask
  task step(input logic [3:0] c, input logic [7:0] p, q, input logic d);
    u_core.op(c, p, q, d);
    k = (c == OP_SUB || c == OP_SUBB) ? 255 - q : q;
    n = (c == OP_SUB) ? 1 : (c == OP_ADDC || c == OP_SUBB) ? f[0] : 0;
    s = p + k + n;
    case (c)
      OP_AND: r = p & q;
      OP_OR: r = p | q;
      OP_XOR: r = p ^ q;
      OP_SWAP: r = {p[3:0], p[7:4]};
      OP_PASS: r = p;
      OP_CLEAR: r = 0;
      default: r = s & 255;
    endcase
    if (c inside {[1:4]}) f = {s[7], p[7] == k[7] && s[7] != p[7], r == 0,
      (p & 15) + (k & 15) + n > 15, s > 255};
    else if (c inside {[5:7]}) {f[4], f[2]} = {r[7], r == 0};
    else if (c == OP_CLEAR) f[2] = 1'b1;
    else if (d) f = r[4:0];
    @(negedge CLK_SYS);
    chk(FLAGS_OUT, {3'b000, f});
    chk(RESULT, r[7:0]);
    chk({7'h00, RESULT_WR}, {7'h00, !d});
  endtask
  initial begin
    repeat (2) @(posedge CLK_SYS);
    SRST <= 1'b0;
    @(negedge CLK_SYS);
    chk(FLAGS_OUT, 8'h00);
    u_core.acc(1'b1, 8'hD8, 8'hFF);
    rdq(8'hD8, 8'h1F);
    u_core.acc(1'b1, 8'h10, 8'h00);
    rdq(8'h10, 8'h00);
    rdq(8'hD8, 8'h1F);
    u_core.acc(1'b1, 8'hD8, 8'h1B);
    f = 5'h1B;
    step(OP_CLEAR, 8'h55, 8'h0F, 1'b1);
    $display("register tests done");
    for (i = 0; i < 400; i++) begin
      t = rnd();
      o = t[3:0] % 4'hA;
      step(o, t[15:8], t[16] ? 8'h00 - t[15:8] : t[23:16], t[24]);
    end
    $display("random ops done");
    finish_test();
  end
  initial begin
    #40000;
    errors++;
    finish_test();
  end
endmodule // alu_status_flags_tb

// ### tb/core_model.sv
/* Core side: issues ALU ops and register accesses.
   Assumes callers start after reset release. */
`timescale 1ns/1ps
module core_model (
  input wire logic CLK_SYS,
  output logic OP_VALID = 0,
  output logic [3:0] OP_CODE = 0,
  output logic [7:0] OP_A = 0,
  output logic [7:0] OP_B = 0,
  output logic DEST_IS_FLAGS = 0,
  output logic [7:0] REG_ADDR = 0,
  output logic [7:0] REG_WDATA = 0,
  output logic REG_WR = 0,
  output logic REG_RD = 0
);
  task op(input logic [3:0] c, input logic [7:0] a, b, input logic d);
    @(posedge CLK_SYS);
    {OP_VALID, OP_CODE, OP_A, OP_B, DEST_IS_FLAGS} <= {1'b1, c, a, b, d};
    @(posedge CLK_SYS);
    {OP_VALID, OP_A, OP_B} <= {1'b0, ~OP_A, ~OP_B};
  endtask
  task acc(input logic w, input logic [7:0] a, d);
    @(posedge CLK_SYS);
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} <= {w, !w, a, d};
    @(posedge CLK_SYS);
    {REG_WR, REG_RD, REG_WDATA} <= {2'b00, ~REG_WDATA};
  endtask
endmodule // core_model
